// ===== rtl/ccs_pkg.sv
// Constants and types shared by the common command and status unit.
package ccs_pkg;

  // Standard event register and mask bit positions.
  localparam int ESR_PON = 7;
  localparam int ESR_CME = 5;
  localparam int ESR_EXE = 4;
  localparam int ESR_DDE = 3;
  localparam int ESR_QYE = 2;
  localparam int ESR_OPC = 0;

  // Status byte bit positions.
  localparam int STB_OPER = 7;
  localparam int STB_MSS = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int STB_QUES = 3;
  localparam int STB_ERRQ = 2;

  // Reset values and fixed masks.
  localparam logic [7:0] ESR_RESET = 8'h00;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] ESR_USED = 8'hBD;
  localparam logic [7:0] SRE_USED = 8'hBF;

  // Answer values.
  localparam logic [7:0] ASCII_ONE = 8'h31;
  localparam logic [7:0] TST_PASS = 8'h00;
  localparam logic [7:0] TST_FAIL = 8'h01;

  // Setting memory.
  localparam logic [7:0] SLOT_FIRST = 8'h01;
  localparam logic [7:0] SLOT_LAST = 8'h28;
  localparam int SLOT_COUNT = 40;
  localparam int SLOT_AW = 6;
  localparam int IDX_W = 6;

  typedef enum logic [3:0] {
    CMD_CLS = 4'h0,
    CMD_ESE = 4'h1,
    CMD_ESEQ = 4'h2,
    CMD_ESRQ = 4'h3,
    CMD_IDNQ = 4'h4,
    CMD_OPC = 4'h5,
    CMD_OPCQ = 4'h6,
    CMD_RCL = 4'h7,
    CMD_RST = 4'h8,
    CMD_SAV = 4'h9,
    CMD_SRE = 4'hA,
    CMD_SREQ = 4'hB,
    CMD_STBQ = 4'hC,
    CMD_TRG = 4'hD,
    CMD_TSTQ = 4'hE,
    CMD_UNKNOWN = 4'hF
  } ccs_cmd_e;

  typedef enum logic [1:0] {
    RESP_INT = 2'h0,
    RESP_CHAR = 2'h1
  } ccs_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPCQ = 2'b01,
    ST_TEST = 2'b11,
    ST_IDN = 2'b10
  } ccs_state_e;

  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] ovp;
    logic [15:0] ocp;
  } ccs_setting_s;

  typedef struct packed {
    ccs_kind_e kind;
    logic [7:0] data;
    logic last;
  } ccs_resp_s;

endpackage

// ===== rtl/ccs_unit.sv
// Common command interpreter with standard event and status byte logic.
`timescale 1ns/1ns
module ccs_unit
  import ccs_pkg::*;
#(
  // Identity text is arbitrary; it only shows the field layout.
  parameter int IDN_LEN = 40,
  parameter logic [8*IDN_LEN-1:0] IDN_TEXT = "MAKER,UNIT-100-1 01-01-2000,S000001,V1.0"
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_star,
  input wire ccs_cmd_e cmd_code,
  input wire logic [7:0] cmd_arg,
  output logic cmd_ready,
  output logic resp_valid,
  output ccs_resp_s resp,
  input wire logic serial_poll,
  output logic [7:0] poll_byte,
  input wire logic exe_err,
  input wire logic dde_err,
  input wire logic qye_err,
  input wire logic ops_pending,
  input wire logic oper_summary,
  input wire logic ques_summary,
  input wire logic msg_avail,
  input wire logic errq_nonempty,
  output logic clr_status,
  output logic reset_req,
  input wire ccs_setting_s set_now,
  output logic set_load,
  output ccs_setting_s set_out,
  input wire logic trig_armed,
  input wire logic [15:0] trig_level,
  output logic trig_fire,
  output logic [15:0] trig_volt,
  output logic test_start,
  input wire logic test_done,
  input wire logic test_fail,
  output logic [7:0] status_byte
);

  function automatic logic slot_ok(input logic [7:0] n);
    slot_ok = (n >= SLOT_FIRST) && (n <= SLOT_LAST);
  endfunction

  function automatic logic [SLOT_AW-1:0] slot_addr(input logic [7:0] n);
    logic [7:0] d;
    d = n - SLOT_FIRST;
    slot_addr = d[SLOT_AW-1:0];
  endfunction

  ccs_state_e state_r;
  logic [7:0] esr_r;
  logic [7:0] ese_r;
  logic [7:0] sre_r;
  logic pon_pend_r;
  logic opc_armed_r;
  logic rqs_r;
  logic mss_q_r;
  logic [IDX_W-1:0] idx_r;
  ccs_setting_s slot_mem [SLOT_COUNT];
  logic take;
  logic known;
  logic [7:0] ev_set;
  logic [7:0] stb_w;
  logic mss_w;
  logic [7:0] ev_clr_mask;

  assign cmd_ready = (state_r == ST_IDLE);
  assign take = cmd_valid && cmd_ready;
  assign known = cmd_star && (cmd_code != CMD_UNKNOWN);

  always_comb begin
    stb_w = 8'h00;
    stb_w[STB_OPER] = oper_summary;
    stb_w[STB_ESB] = |(esr_r & ese_r);
    stb_w[STB_MAV] = msg_avail;
    stb_w[STB_QUES] = ques_summary;
    stb_w[STB_ERRQ] = errq_nonempty;
    stb_w[STB_MSS] = |(stb_w & sre_r & SRE_USED);
  end
  assign mss_w = stb_w[STB_MSS];
  assign status_byte = stb_w;

  // Events raised this cycle; they win over any clear in the same cycle.
  always_comb begin
    ev_set = 8'h00;
    ev_set[ESR_PON] = pon_pend_r;
    ev_set[ESR_CME] = take && !known;
    ev_set[ESR_EXE] = exe_err || (take && known && !slot_ok(cmd_arg) &&
                      (cmd_code == CMD_RCL || cmd_code == CMD_SAV));
    ev_set[ESR_DDE] = dde_err;
    ev_set[ESR_QYE] = qye_err;
    ev_set[ESR_OPC] = opc_armed_r && !ops_pending;
    ev_clr_mask = 8'hFF;
    if (take && known && (cmd_code == CMD_CLS || cmd_code == CMD_ESRQ)) begin
      ev_clr_mask = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      esr_r <= ESR_RESET;
    end else begin
      esr_r <= ((esr_r & ev_clr_mask) | ev_set) & ESR_USED;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pon_pend_r <= 1'b1;
    end else begin
      pon_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ese_r <= ESE_RESET;
      sre_r <= SRE_RESET;
    end else if (take && known) begin
      if (cmd_code == CMD_ESE) begin
        ese_r <= cmd_arg;
      end else if (cmd_code == CMD_SRE) begin
        sre_r <= cmd_arg & SRE_USED;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      opc_armed_r <= 1'b0;
    end else if (take && known && cmd_code == CMD_OPC) begin
      opc_armed_r <= 1'b1;
    end else if (!ops_pending || (take && known && cmd_code == CMD_CLS)) begin
      opc_armed_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rqs_r <= 1'b0;
      mss_q_r <= 1'b0;
      poll_byte <= 8'h00;
    end else begin
      mss_q_r <= mss_w;
      if (mss_w && !mss_q_r) begin
        rqs_r <= 1'b1;
      end else if (serial_poll || (take && known && cmd_code == CMD_CLS)) begin
        rqs_r <= 1'b0;
      end
      if (serial_poll) begin
        poll_byte <= {stb_w[7], rqs_r, stb_w[5:0]};
      end
    end
  end

  // Command state machine; queries that must wait hold cmd_ready low.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      idx_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          idx_r <= '0;
          if (take && known) begin
            if (cmd_code == CMD_OPCQ) begin
              state_r <= ST_OPCQ;
            end else if (cmd_code == CMD_TSTQ) begin
              state_r <= ST_TEST;
            end else if (cmd_code == CMD_IDNQ) begin
              state_r <= ST_IDN;
            end
          end
        end
        ST_OPCQ: begin
          if (!ops_pending) begin
            state_r <= ST_IDLE;
          end
        end
        ST_TEST: begin
          if (test_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_IDN: begin
          idx_r <= idx_r + 1'b1;
          if (idx_r == IDX_W'(IDN_LEN - 1)) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Answers to the host.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      resp_valid <= 1'b0;
      resp.kind <= RESP_INT;
      resp.last <= 1'b1;
      if (state_r == ST_IDLE && take && known) begin
        if (cmd_code == CMD_ESEQ) begin
          resp_valid <= 1'b1;
          resp.data <= ese_r;
        end else if (cmd_code == CMD_ESRQ) begin
          resp_valid <= 1'b1;
          resp.data <= esr_r;
        end else if (cmd_code == CMD_SREQ) begin
          resp_valid <= 1'b1;
          resp.data <= sre_r;
        end else if (cmd_code == CMD_STBQ) begin
          resp_valid <= 1'b1;
          resp.data <= stb_w;
        end
      end else if (state_r == ST_OPCQ && !ops_pending) begin
        resp_valid <= 1'b1;
        resp.kind <= RESP_CHAR;
        resp.data <= ASCII_ONE;
      end else if (state_r == ST_TEST && test_done) begin
        resp_valid <= 1'b1;
        resp.data <= test_fail ? TST_FAIL : TST_PASS;
      end else if (state_r == ST_IDN) begin
        resp_valid <= 1'b1;
        resp.kind <= RESP_CHAR;
        resp.data <= IDN_TEXT[8*(IDN_LEN-1-int'(idx_r)) +: 8];
        resp.last <= (idx_r == IDX_W'(IDN_LEN - 1));
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (take && known && cmd_code == CMD_SAV && slot_ok(cmd_arg)) begin
      slot_mem[slot_addr(cmd_arg)] <= set_now;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      set_load <= 1'b0;
      set_out <= '0;
    end else begin
      set_load <= 1'b0;
      if (take && known && cmd_code == CMD_RCL && slot_ok(cmd_arg)) begin
        set_load <= 1'b1;
        set_out <= slot_mem[slot_addr(cmd_arg)];
      end
    end
  end

  // Pulses to the rest of the instrument.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      clr_status <= 1'b0;
      reset_req <= 1'b0;
      trig_fire <= 1'b0;
      trig_volt <= 16'h0000;
      test_start <= 1'b0;
    end else begin
      // clear operation, questionable and error queue
      clr_status <= take && known && cmd_code == CMD_CLS;
      reset_req <= take && known && cmd_code == CMD_RST;
      test_start <= take && known && cmd_code == CMD_TSTQ;
      trig_fire <= 1'b0;
      if (take && known && cmd_code == CMD_TRG && trig_armed) begin
        trig_fire <= 1'b1;
        trig_volt <= trig_level;
      end
    end
  end

  sequence s_take(ccs_cmd_e c);
    take && cmd_star && cmd_code == c;
  endsequence

  sequence s_wait_done;
    (state_r == ST_OPCQ) && !ops_pending;
  endsequence

  chk_cls_clears: assert property (@(posedge mclk) disable iff (!reset_n)
    s_take(CMD_CLS) && !exe_err && !dde_err && !qye_err |=> (esr_r[5:2] == 4'h0) && clr_status)
    else $error("clear status left error bits or no clear pulse");

  chk_ese_store: assert property (@(posedge mclk) disable iff (!reset_n)
    s_take(CMD_ESE) |=> ese_r == $past(cmd_arg) ##1 $stable(ese_r) || cmd_valid)
    else $error("event mask not stored");

  chk_esb_summary: assert property (@(posedge mclk) disable iff (!reset_n)
    status_byte[STB_ESB] == |(esr_r & ese_r))
    else $error("event summary bit wrong");

  chk_unused_bits: assert property (@(posedge mclk) disable iff (!reset_n)
    esr_r[6] == 1'b0 && esr_r[1] == 1'b0)
    else $error("unused event bits set");

  chk_eseq_answer: assert property (@(posedge mclk) disable iff (!reset_n)
    s_take(CMD_ESEQ) |=> resp_valid && resp.data == ese_r && $stable(ese_r))
    else $error("mask query answer wrong");

  chk_esr_read: assert property (@(posedge mclk) disable iff (!reset_n)
    s_take(CMD_ESRQ) && !exe_err && !dde_err && !qye_err && !opc_armed_r
    |=> resp_valid && resp.data == $past(esr_r) && esr_r[5:0] == 6'h00)
    else $error("event read did not answer and clear");

  chk_unknown_cme: assert property (@(posedge mclk) disable iff (!reset_n)
    take && !known |=> esr_r[ESR_CME])
    else $error("unknown command did not set command error");

  chk_opc_event: assert property (@(posedge mclk) disable iff (!reset_n)
    s_take(CMD_OPC) ##1 !ops_pending |=> esr_r[ESR_OPC])
    else $error("completion bit not set");

  chk_opcq_wait: assert property (@(posedge mclk) disable iff (!reset_n)
    s_take(CMD_OPCQ) ##1 ops_pending |-> !cmd_ready && !resp_valid)
    else $error("completion query did not stall");

  chk_opcq_answer: assert property (@(posedge mclk) disable iff (!reset_n)
    s_wait_done |=> resp_valid && resp.data == ASCII_ONE && cmd_ready)
    else $error("completion query answer wrong");

  chk_recall_load: assert property (@(posedge mclk) disable iff (!reset_n)
    s_take(CMD_RCL) && slot_ok(cmd_arg) |=> set_load ##1 !set_load)
    else $error("recall did not load settings");

  chk_save_recall: assert property (@(posedge mclk) disable iff (!reset_n)
    s_take(CMD_SAV) && slot_ok(cmd_arg) ##1 !(take && cmd_code == CMD_SAV)
    ##1 s_take(CMD_RCL) && cmd_arg == $past(cmd_arg, 2) |=> set_out == $past(set_now, 3))
    else $error("recall did not reproduce saved settings");

  chk_trg_level: assert property (@(posedge mclk) disable iff (!reset_n)
    s_take(CMD_TRG) && trig_armed |=> trig_fire && trig_volt == $past(trig_level))
    else $error("trigger did not drive level");

  chk_tst_answer: assert property (@(posedge mclk) disable iff (!reset_n)
    state_r == ST_TEST && test_done |=> resp_valid && resp.data == {7'h00, $past(test_fail)})
    else $error("self-test answer wrong");

  chk_mss_summary: assert property (@(posedge mclk) disable iff (!reset_n)
    status_byte[STB_MSS] == |(status_byte & sre_r & SRE_USED))
    else $error("master summary bit wrong");

  chk_poll_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    serial_poll && !(mss_w && !mss_q_r) |=> !rqs_r)
    else $error("serial poll did not clear request bit");

  chk_pon_once: assert property (@(posedge mclk)
    !reset_n ##1 reset_n |=> esr_r[ESR_PON] && !pon_pend_r)
    else $error("power-on flag not set after power-up");

endmodule

// ===== dv/ccs_host_model.sv
// Host controller model that issues commands and collects answer bytes.
`timescale 1ns/1ns
module ccs_host_model
  import ccs_pkg::*;
(
  input wire logic mclk,
  input wire logic cmd_ready,
  input wire logic resp_valid,
  input wire ccs_resp_s resp,
  output logic cmd_valid,
  output logic cmd_star,
  output ccs_cmd_e cmd_code,
  output logic [7:0] cmd_arg
);
  ccs_resp_s rq [$];
  logic hung;

  initial begin
    cmd_valid = 1'b0;
    cmd_star = 1'b1;
    cmd_code = CMD_STBQ;
    cmd_arg = 8'h00;
    hung = 1'b0;
  end

  always @(posedge mclk) begin
    if (resp_valid === 1'b1) begin
      rq.push_back(resp);
    end
  end

  // caller-chosen header star, any 8-bit argument, any slot number.
  task automatic send(input ccs_cmd_e code, input logic [7:0] arg, input logic star);
    int n;
    @(posedge mclk);
    #1;
    cmd_code = code;
    cmd_arg = arg;
    cmd_star = star;
    cmd_valid = 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 500);
    hung = (cmd_ready !== 1'b1);
    #1;
    cmd_valid = 1'b0;
    // Released lines show the inverse so a stale value is never mistaken for a command.
    cmd_code = ccs_cmd_e'(~code);
    cmd_arg = ~arg;
  endtask
endmodule

// ===== dv/common_command_status_unit_tb.sv
// Self-checking bench for the common command and status unit.
`timescale 1ns/1ns
module common_command_status_unit_tb;
  import ccs_pkg::*;
  localparam int IDN_LEN = 18;
  localparam logic [8*IDN_LEN-1:0] IDN_TEXT = "MK,U-5-2 1,S9,V1.0";
  logic mclk, reset_n, cmd_valid, cmd_star, cmd_ready, resp_valid, serial_poll;
  logic exe_err, dde_err, qye_err, ops_pending, oper_summary, ques_summary;
  logic msg_avail, errq_nonempty, clr_status, reset_req, set_load, trig_armed;
  logic trig_fire, test_start, test_fin, test_fail;
  logic [7:0] cmd_arg, poll_byte, status_byte, d, e, m;
  logic [7:0] sl [4];
  logic [15:0] trig_level, trig_volt;
  logic [31:0] seed, r;
  ccs_cmd_e cmd_code;
  ccs_resp_s resp, x;
  ccs_setting_s set_now, set_out;
  ccs_setting_s mem [1:40];
  int miscompares, total_checks;

  ccs_unit #(.IDN_LEN(IDN_LEN), .IDN_TEXT(IDN_TEXT)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_star(cmd_star),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
    .resp_valid(resp_valid), .resp(resp), .serial_poll(serial_poll),
    .poll_byte(poll_byte), .exe_err(exe_err), .dde_err(dde_err), .qye_err(qye_err),
    .ops_pending(ops_pending), .oper_summary(oper_summary),
    .ques_summary(ques_summary), .msg_avail(msg_avail), .errq_nonempty(errq_nonempty),
    .clr_status(clr_status), .reset_req(reset_req), .set_now(set_now),
    .set_load(set_load), .set_out(set_out), .trig_armed(trig_armed),
    .trig_level(trig_level), .trig_fire(trig_fire), .trig_volt(trig_volt),
    .test_start(test_start), .test_done(test_fin), .test_fail(test_fail),
    .status_byte(status_byte)
  );

  ccs_host_model u_host (
    .mclk(mclk), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp),
    .cmd_valid(cmd_valid), .cmd_star(cmd_star), .cmd_code(cmd_code), .cmd_arg(cmd_arg)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic test_done();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic cmd(input ccs_cmd_e c, input logic [7:0] a, input logic s);
    u_host.send(c, a, s);
    if (u_host.hung) begin
      miscompares++;
      test_done();
    end
  endtask

  task automatic get(output ccs_resp_s y);
    int n;
    for (n = 0; n < 400 && u_host.rq.size() == 0; n++) @(posedge mclk);
    if (u_host.rq.size() == 0) begin
      miscompares++;
      test_done();
    end else begin
      y = u_host.rq.pop_front();
    end
  endtask

  task automatic ask(input ccs_cmd_e c, input logic [7:0] a, output logic [7:0] v);
    ccs_resp_s y;
    cmd(c, a, 1'b1);
    get(y);
    chk(y.kind, RESP_INT);
    v = y.data;
  endtask

  // Waits for set_load, trig_fire, test_start, clr_status or reset_req by index.
  task automatic wait_for(input int w);
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if ((w == 0 && set_load) || (w == 1 && trig_fire) || (w == 2 && test_start) ||
          (w == 3 && clr_status) || (w == 4 && reset_req)) return;
    end
    miscompares++;
    test_done();
  endtask

  task automatic pulse(input logic [2:0] v);
    tick();
    {exe_err, dde_err, qye_err} = v;
    tick();
    {exe_err, dde_err, qye_err} = 3'h0;
  endtask

  initial begin
    seed = 32'h9B770259;
    miscompares = 0;
    total_checks = 0;
    reset_n = 1'b0;
    serial_poll = 1'b0;
    {exe_err, dde_err, qye_err} = 3'h0;
    ops_pending = 1'b0;
    {oper_summary, ques_summary, msg_avail, errq_nonempty} = 4'h0;
    trig_armed = 1'b0;
    trig_level = 16'h0000;
    test_fin = 1'b0;
    test_fail = 1'b0;
    set_now = '0;
    repeat (20) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    ask(CMD_ESRQ, 8'h00, d);
    chk(d, 8'h80);
    ask(CMD_ESRQ, 8'h00, d);
    chk(d, 8'h00);
    ask(CMD_ESEQ, 8'h00, d);
    chk(d, ESE_RESET);
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      m = r[7:0];
      e = (r[11] && !r[12]) ? 8'h00 : {2'b00, r[11], r[10:8], 2'b00};
      cmd(CMD_ESE, m, 1'b1);
      pulse(r[10:8]);
      if (r[11]) cmd(r[12] ? CMD_UNKNOWN : CMD_CLS, 8'h00, !r[12]);
      repeat (2) tick();
      chk(status_byte[STB_ESB], |(e & m));
      ask(CMD_ESEQ, 8'h00, d);
      chk(d, m);
      ask(CMD_ESRQ, 8'h00, d);
      chk(d, e);
    end
    cmd(CMD_ESE, 8'h3C, 1'b1);
    pulse(3'h7);
    cmd(CMD_CLS, 8'h00, 1'b1);
    wait_for(3);
    chk(status_byte[STB_ESB], 1'b0);
    ask(CMD_ESRQ, 8'h00, d);
    chk(d, 8'h00);
    ask(CMD_ESEQ, 8'h00, d);
    chk(d, 8'h3C);
    tick();
    ops_pending = 1'b1;
    cmd(CMD_OPC, 8'h00, 1'b1);
    ask(CMD_ESRQ, 8'h00, d);
    chk(d, 8'h00);
    tick();
    ops_pending = 1'b0;
    repeat (3) tick();
    ask(CMD_ESRQ, 8'h00, d);
    chk(d, 8'h01);
    tick();
    ops_pending = 1'b1;
    cmd(CMD_OPCQ, 8'h00, 1'b1);
    repeat (4) tick();
    chk(cmd_ready, 1'b0);
    chk(64'(u_host.rq.size()), 64'h0);
    ops_pending = 1'b0;
    get(x);
    chk(x.data, ASCII_ONE);
    chk(x.kind, RESP_CHAR);
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      sl[k] = 8'(r[15:0] % 40 + 1);
      tick();
      set_now = {rnd(), rnd()};
      mem[sl[k]] = set_now;
      cmd(CMD_SAV, sl[k], 1'b1);
    end
    for (int k = 3; k >= 0; k--) begin
      cmd(CMD_RCL, sl[k], 1'b1);
      wait_for(0);
      chk(set_out, mem[sl[k]]);
    end
    cmd(CMD_RCL, 8'h00, 1'b1);
    cmd(CMD_SAV, 8'h29, 1'b1);
    ask(CMD_ESRQ, 8'h00, d);
    chk(d, 8'h10);
    tick();
    r = rnd();
    trig_level = r[15:0];
    trig_armed = 1'b1;
    cmd(CMD_TRG, 8'h00, 1'b1);
    wait_for(1);
    chk(trig_volt, trig_level);
    tick();
    trig_armed = 1'b0;
    cmd(CMD_TRG, 8'h00, 1'b1);
    repeat (4) begin
      @(posedge mclk);
      chk(trig_fire, 1'b0);
    end
    for (int f = 0; f < 2; f++) begin
      cmd(CMD_TSTQ, 8'h00, 1'b1);
      wait_for(2);
      repeat (3) tick();
      test_fin = 1'b1;
      test_fail = f[0];
      tick();
      test_fin = 1'b0;
      get(x);
      chk(x.data, f[0] ? TST_FAIL : TST_PASS);
    end
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      tick();
      {oper_summary, ques_summary, msg_avail, errq_nonempty} = r[3:0];
      tick();
      chk(status_byte & 8'h9C, {r[3], 2'b00, r[1], r[2], r[0], 2'b00});
    end
    tick();
    {oper_summary, ques_summary, msg_avail, errq_nonempty} = 4'h0;
    ask(CMD_STBQ, 8'h00, d);
    chk(d, 8'h00);
    cmd(CMD_SRE, 8'h20, 1'b1);
    cmd(CMD_UNKNOWN, 8'h00, 1'b1);
    ask(CMD_STBQ, 8'h00, d);
    chk(d, 8'h60);
    for (int k = 0; k < 2; k++) begin
      tick();
      serial_poll = 1'b1;
      tick();
      serial_poll = 1'b0;
      chk(poll_byte, k == 0 ? 8'h60 : 8'h20);
    end
    chk(status_byte, 8'h60);
    ask(CMD_SREQ, 8'h00, d);
    chk(d, 8'h20);
    cmd(CMD_IDNQ, 8'h00, 1'b1);
    for (int i = 0; i < IDN_LEN; i++) begin
      get(x);
      chk(x.data, IDN_TEXT[8*(IDN_LEN-i)-1 -: 8]);
      chk(x.last, i == IDN_LEN - 1);
      chk(x.kind, RESP_CHAR);
    end
    cmd(CMD_ESE, 8'hFF, 1'b0);
    ask(CMD_ESEQ, 8'h00, d);
    chk(d, 8'h3C);
    ask(CMD_ESRQ, 8'h00, d);
    chk(d, 8'h20);
    cmd(CMD_RST, 8'h00, 1'b1);
    wait_for(4);
    tick();
    chk(reset_req, 1'b0);
    test_done();
  end
endmodule
